// >>> hw/otp_prog_cfg.svh
/*
 Constants for the one-time-programmable memory programming decoder.
 Assumes inclusion by its bare name from the package and design files.
*/
`ifndef OTP_PROG_CFG_SVH
`define OTP_PROG_CFG_SVH
`define ADDR_WIDTH 16
`define DATA_WIDTH 8
`define SIG_COUNT 4
`define CRYPT_TOP 16'h003f
`define SIG_BASE 16'h0030
`define PULSE_MIN_NS 100
`define CLK_PERIOD_NS 20
`define PULSE_MIN_CYC ((`PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SIZE_SMALL 2'd0
`define SIZE_MIDDLE 2'd1
`define SIZE_LARGE 2'd2
`endif

// >>> hw/otp_prog_pkg.sv
/*
 Types shared by the programming decoder files.
 Assumes otp_prog_cfg.svh is on the include path.
*/
`default_nettype none
`include "otp_prog_cfg.svh"
package otp_prog_pkg;
    typedef enum logic [2:0] {
        mode_idle,
        mode_prog_code,
        mode_verify_code,
        mode_prog_crypt,
        mode_read_sig,
        mode_prog_lock1,
        mode_prog_lock2,
        mode_prog_lock3
    } prog_mode_t;

    typedef enum logic [1:0] {
        pulse_wait,
        pulse_low,
        pulse_done
    } pulse_state_t;
endpackage : otp_prog_pkg
`default_nettype wire

// >>> hw/pin_sync3.sv
/*
 Three-stage input synchroniser with agreement filter.
 Assumes asynchronous pin inputs and one clock.
*/
`default_nettype none
module pin_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    if (WIDTH < 1) begin : g_bad_width
        $error("bad WIDTH");
    end

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Each bit moves only once the second and third stages agree.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            level_out <= INIT;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : pin_sync3
`default_nettype wire

// >>> hw/otp_program_mode_decoder.sv
/*
 Parallel programming and verify front end of the one-time-programmable code memory.
 Assumes the memory array and signature store sit outside, reached through the array ports;
 all pin inputs are asynchronous to ref_clk.
*/
`default_nettype none
`include "otp_prog_cfg.svh"

// What this block does
// - Address bits 0-15 come from port 1, port 2 bits 0-5, port 3 bits 4-5.
// - Data byte travels on port 0; programmer drives on program, device on verify.
// - Top address bit is 13, 14 or 15 depending on memory size variant.
// - Reset high and store-enable low in all modes; mode from five pins.
// - Code program and code verify are decoded from their pin patterns.
// - Encryption array program covers 0-3Fh, like code program with port 3.6 low.
// - Lock bits 1, 2, 3 are chosen by patterns 1111, 1100, 0110.
// - Four signature bytes are read with all mode pins low, no high voltage.
module otp_program_mode_decoder
    import otp_prog_pkg::*;
#(
    parameter logic [1:0] SIZE_VARIANT = `SIZE_LARGE,
    parameter int PULSE_MIN_CYCLES = `PULSE_MIN_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic reset_pin,
    input wire logic program_store_enable_n,
    input wire logic latch_strobe_program_pulse,
    input wire logic external_access_program_voltage,
    input wire logic [7:0] port1_in,
    input wire logic [7:0] port2_in,
    input wire logic [7:0] port3_in,
    input wire logic [7:0] port0_in,
    output logic [7:0] port0_out,
    output logic port0_oe,
    output logic [15:0] array_addr,
    output logic [7:0] array_wdata,
    output logic array_write,
    output logic crypt_write,
    output logic [2:0] lock_write,
    output logic sig_read,
    input wire logic [7:0] array_rdata,
    input wire logic [7:0] sig_rdata,
    output logic [2:0] mode_state
);
    // Refuse parameter values that the decoder cannot serve.
    if (SIZE_VARIANT > `SIZE_LARGE) begin : g_bad_size
        $error("bad SIZE_VARIANT");
    end
    if (PULSE_MIN_CYCLES < 1 || PULSE_MIN_CYCLES > 255) begin : g_bad_pulse
        $error("bad PULSE_MIN_CYCLES");
    end

    // The pulse counter is eight bits wide, so the minimum width is capped at 255 cycles.
    localparam logic [7:0] PULSE_CYC = 8'(PULSE_MIN_CYCLES);

    logic [7:0] p1_s, p2_s, p3_s, p0_s;
    logic [2:0] ctl_s;
    prog_mode_t mode_d, mode_q;
    pulse_state_t pst_q;
    logic [7:0] pulse_cnt_q;
    logic [15:0] addr_d;

    // Every pin passes the three-stage filter, so a level counts about four edges after it changes.
    pin_sync3 #(.WIDTH(8), .INIT(8'hff)) u_p1 (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(port1_in),
        .level_out(p1_s)
    );
    pin_sync3 #(.WIDTH(8), .INIT(8'hff)) u_p2 (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(port2_in),
        .level_out(p2_s)
    );
    pin_sync3 #(.WIDTH(8), .INIT(8'hff)) u_p3 (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(port3_in),
        .level_out(p3_s)
    );
    pin_sync3 #(.WIDTH(8), .INIT(8'hff)) u_p0 (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(port0_in),
        .level_out(p0_s)
    );
    pin_sync3 #(.WIDTH(3), .INIT(3'h3)) u_ctl (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in({reset_pin, program_store_enable_n, latch_strobe_program_pulse}),
        .level_out(ctl_s)
    );

    // Bit order of a code: {port2.6, port2.7, port3.3, port3.6, port3.7}.
    function automatic prog_mode_t decode_mode(input logic rst_hi, input logic pse_n,
                                               input logic [4:0] pins, input logic vpp);
        prog_mode_t m;
        m = mode_idle;
        // Mode pins are trusted only while the reset pin is high and store-enable is low.
        if (rst_hi && !pse_n) begin
            case (pins)
                5'b01111: m = vpp ? mode_prog_code : mode_idle;
                5'b00011: m = mode_verify_code;
                5'b01101: m = mode_prog_crypt;
                5'b00000: m = vpp ? mode_idle : mode_read_sig;
                5'b11111: m = mode_prog_lock1;
                5'b11100: m = mode_prog_lock2;
                5'b10110: m = mode_prog_lock3;
                default: m = mode_idle;
            endcase
            // Verify pattern ignores port 2.7; cover both values.
            if (pins[4] == 1'b0 && pins[2:0] == 3'b011) m = mode_verify_code;
            if (pins[4] == 1'b0 && pins[2:0] == 3'b000 && !vpp) m = mode_read_sig;
        end
        return m;
    endfunction : decode_mode

    // Only these modes may turn a pulse into a write.
    function automatic logic is_program(input prog_mode_t m);
        return m == mode_prog_code || m == mode_prog_crypt || m == mode_prog_lock1 ||
               m == mode_prog_lock2 || m == mode_prog_lock3;
    endfunction : is_program

    // The high voltage level arrives as a logic flag from the level detector outside.
    // The flag resets low so that no pulse is honoured until the level is really present.
    logic vpp_s;
    pin_sync3 #(.WIDTH(1), .INIT(1'b0)) u_vpp (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(external_access_program_voltage),
        .level_out(vpp_s)
    );

    always_comb begin
        mode_d = decode_mode(ctl_s[2], ctl_s[1], {p2_s[6], p2_s[7], p3_s[3], p3_s[6], p3_s[7]}, vpp_s);
    end

    // Unimplemented top bits read as zero for smaller variants.
    always_comb begin
        addr_d = {p3_s[5], p3_s[4], p2_s[5:0], p1_s};
        case (SIZE_VARIANT)
            `SIZE_SMALL: addr_d[15:14] = 2'b00;
            `SIZE_MIDDLE: addr_d[15] = 1'b0;
            default: ;
        endcase
    end

    // Mode, address and write data are registered so that every output comes from a flip-flop.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mode_q <= mode_idle;
            array_addr <= 16'h0000;
            array_wdata <= 8'h00;
            mode_state <= 3'h0;
        end else begin
            mode_q <= mode_d;
            mode_state <= 3'(mode_d);
            array_addr <= (mode_d == mode_prog_crypt) ? (addr_d & `CRYPT_TOP) : addr_d;
            array_wdata <= p0_s;
        end
    end

    // A low pulse on the program pin, held long enough, fires one write at its rising end.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pst_q <= pulse_wait;
            pulse_cnt_q <= 8'h00;
            array_write <= 1'b0;
            crypt_write <= 1'b0;
            lock_write <= 3'b000;
        end else begin
            array_write <= 1'b0;
            crypt_write <= 1'b0;
            lock_write <= 3'b000;
            case (pst_q)
                pulse_wait: begin
                    pulse_cnt_q <= 8'h00;
                    if (!ctl_s[0] && vpp_s && is_program(mode_q)) pst_q <= pulse_low;
                end
                pulse_low: begin
                    // Losing the voltage or the mode mid-pulse abandons the pulse without a write.
                    if (!vpp_s || mode_d != mode_q) begin
                        pst_q <= pulse_wait;
                    end else if (ctl_s[0]) begin
                        pst_q <= pulse_done;
                    end else if (pulse_cnt_q != 8'hff) begin
                        pulse_cnt_q <= pulse_cnt_q + 8'h01;
                    end
                end
                pulse_done: begin
                    pst_q <= pulse_wait;
                    // The counter holds one less than the number of low cycles seen.
                    if (pulse_cnt_q >= PULSE_CYC - 8'h01) begin
                        array_write <= (mode_q == mode_prog_code);
                        crypt_write <= (mode_q == mode_prog_crypt);
                        lock_write <= {mode_q == mode_prog_lock3, mode_q == mode_prog_lock2,
                                       mode_q == mode_prog_lock1};
                    end
                end
                default: pst_q <= pulse_wait;
            endcase
        end
    end

    // The device drives port 0 only in verify and signature modes.
    // Port 0 data follow the mode by one edge, so the array read data have settled first.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            port0_out <= 8'h00;
            port0_oe <= 1'b0;
            sig_read <= 1'b0;
        end else begin
            sig_read <= (mode_q == mode_read_sig);
            port0_oe <= (mode_q == mode_verify_code) || (mode_q == mode_read_sig);
            port0_out <= (mode_q == mode_read_sig) ? sig_rdata : array_rdata;
        end
    end
endmodule : otp_program_mode_decoder
`default_nettype wire

// >>> tb/otp_mode_chk.sv
/*
 Concurrent checks on the ports of the programming decoder.
 Assumes one clock and a synchronous active-low reset.
*/
`default_nettype none
module otp_mode_chk #(
    parameter logic [1:0] SIZE_VARIANT = 2'h2
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic reset_pin,
    input wire logic external_access_program_voltage,
    input wire logic [15:0] array_addr,
    input wire logic array_write,
    input wire logic crypt_write,
    input wire logic [2:0] lock_write,
    input wire logic port0_oe,
    input wire logic sig_read,
    input wire logic [2:0] mode_state
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire logic [4:0] wr = {array_write, crypt_write, lock_write};
    one_write_a: assert property ($onehot0(wr)) else $error("two write strobes");
    pulse_once_a: assert property (wr != 5'h0 |=> wr == 5'h0) else $error("long write");
    code_mode_a: assert property (array_write |-> mode_state == 3'h1) else $error("stray write");
    crypt_range_a: assert property (crypt_write |-> mode_state == 3'h3 && array_addr[15:6] == 10'h0)
        else $error("bad crypt write");
    lock_sel_a: assert property (lock_write != 3'h0 |-> mode_state >= 3'h5 &&
        lock_write == 3'h1 << (mode_state - 3'h5)) else $error("bad lock write");
    no_volt_a: assert property ((!external_access_program_voltage) [*8] |-> wr == 5'h0)
        else $error("write without voltage");
    drive_mode_a: assert property (port0_oe |-> $past(mode_state) inside {3'h2, 3'h4})
        else $error("port drive in wrong mode");
    sig_mode_a: assert property (sig_read |-> mode_state == 3'h4 || $past(mode_state) == 3'h4)
        else $error("stray signature read");
    top_bit_a: assert property ((array_addr >> (5'd14 + SIZE_VARIANT)) == 16'h0)
        else $error("address above top bit");
    held_reset_a: assert property ((!reset_pin) [*8] |-> mode_state == 3'h0)
        else $error("mode without reset pin");
    cover property (array_write);
    cover property (crypt_write);
    cover property (sig_read && port0_oe);
endmodule : otp_mode_chk
bind otp_program_mode_decoder otp_mode_chk #(.SIZE_VARIANT(SIZE_VARIANT)) chk_inst (.ref_clk, .rst_b,
    .reset_pin, .external_access_program_voltage, .array_addr, .array_write, .crypt_write,
    .lock_write, .port0_oe, .sig_read, .mode_state);
`default_nettype wire

// >>> tb/otp_programmer_model.sv
/*
 Programming equipment on the pins, plus the array contents it reads back.
 Assumes the bench calls its tasks; one clock.
*/
`default_nettype none
module otp_programmer_model #(
    parameter logic [7:0] SIG_ID = 8'h5c // Arbitrary value.
) (
    input wire logic ref_clk,
    input wire logic [15:0] array_addr,
    input wire logic [7:0] port0_out,
    input wire logic port0_oe,
    output logic reset_pin,
    output logic program_store_enable_n,
    output logic latch_strobe_program_pulse,
    output logic external_access_program_voltage,
    output logic [7:0] port0_in,
    output logic [7:0] port1_in,
    output logic [7:0] port2_in,
    output logic [7:0] port3_in,
    output logic [7:0] array_rdata,
    output logic [7:0] sig_rdata
);
    logic [7:0] data_q = 8'h00;
    logic drive_q = 1'b0;
    // Port 0 has pull-ups, so a bus nobody drives reads all ones.
    assign port0_in = port0_oe ? port0_out : (drive_q ? data_q : 8'hff);
    assign array_rdata = array_addr[7:0] ^ array_addr[15:8] ^ 8'ha5;
    assign sig_rdata = SIG_ID + array_addr[7:0];
    initial begin
        reset_pin = 1'b1;
        program_store_enable_n = 1'b0;
        latch_strobe_program_pulse = 1'b1;
        external_access_program_voltage = 1'b0;
        port1_in = 8'hff;
        port2_in = 8'hff;
        port3_in = 8'hff;
    end
    // Mode m is {p2.6, p2.7, p3.3, p3.6, p3.7}.
    task automatic setup(input logic [4:0] m, input logic v, input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        port1_in <= a[7:0];
        port2_in <= {m[3], m[4], a[13:8]};
        port3_in <= {m[0], m[1], a[15:14], m[2], 3'h7};
        external_access_program_voltage <= v;
        data_q <= d;
        drive_q <= v;
        repeat (8) @(posedge ref_clk);
    endtask : setup
    task automatic pulse(input int n);
        @(posedge ref_clk);
        latch_strobe_program_pulse <= 1'b0;
        repeat (n) @(posedge ref_clk);
        latch_strobe_program_pulse <= 1'b1;
        repeat (12) @(posedge ref_clk);
    endtask : pulse
    task automatic drop_reset_pin();
        @(posedge ref_clk);
        reset_pin <= 1'b0;
    endtask : drop_reset_pin
endmodule : otp_programmer_model
`default_nettype wire

// >>> tb/otp_program_mode_decoder_bench.sv
/*
 Self-checking bench for the programming decoder, middle memory size.
 Assumes the design files and the programmer model are compiled first.
*/
`default_nettype none
module otp_program_mode_decoder_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] SIG_ID = 8'h5c;
    logic ref_clk = 1'b0, rst_b = 1'b0;
    logic reset_pin, program_store_enable_n, latch_strobe_program_pulse, external_access_program_voltage;
    logic [7:0] port0_in, port1_in, port2_in, port3_in, port0_out, array_wdata, array_rdata, sig_rdata;
    logic [15:0] array_addr, wa_q;
    logic port0_oe, array_write, crypt_write, sig_read;
    logic [2:0] lock_write, mode_state;
    logic [4:0] seen_q = 5'h0;
    logic [7:0] wd_q;
    int fails = 0, n_tests = 0, nw_q = 0, cyc = 0;
    always #10 ref_clk = ~ref_clk;
    otp_program_mode_decoder #(.SIZE_VARIANT(2'd1), .PULSE_MIN_CYCLES(5)) otp_program_mode_decoder_inst (
        .ref_clk, .rst_b, .reset_pin, .program_store_enable_n, .latch_strobe_program_pulse,
        .external_access_program_voltage, .port1_in, .port2_in, .port3_in, .port0_in, .port0_out,
        .port0_oe, .array_addr, .array_wdata, .array_write, .crypt_write, .lock_write, .sig_read,
        .array_rdata, .sig_rdata, .mode_state);
    otp_programmer_model #(.SIG_ID(SIG_ID)) prog (.ref_clk, .array_addr, .port0_out, .port0_oe,
        .reset_pin, .program_store_enable_n, .latch_strobe_program_pulse, .external_access_program_voltage,
        .port0_in, .port1_in, .port2_in, .port3_in, .array_rdata, .sig_rdata);
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if ({array_write, crypt_write, lock_write} != 5'h0) begin
            seen_q <= {array_write, crypt_write, lock_write};
            wa_q <= array_addr;
            wd_q <= array_wdata;
            nw_q <= nw_q + 1;
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic op(input logic [4:0] m, input logic v, input logic [15:0] a, input int n,
                      input logic [2:0] ms, input logic [4:0] ew);
        int base;
        base = nw_q;
        prog.setup(m, v, a, a[7:0] ^ 8'hc3);
        chk("mode", 16'(ms), 16'(mode_state));
        chk("oe", 16'(ms == 3'h2 || ms == 3'h4), 16'(port0_oe));
        chk("sig_read", 16'(ms == 3'h4), 16'(sig_read));
        if (ms == 3'h2) chk("rdata", 16'(a[7:0] ^ {1'b0, a[14:8]} ^ 8'ha5), 16'(port0_out));
        if (ms == 3'h4) chk("sig", 16'(SIG_ID + a[7:0]), 16'(port0_out));
        prog.pulse(n);
        chk("writes", 16'(ew), (nw_q != base) ? 16'(seen_q) : 16'h0000);
        chk("count", 16'(ew != 5'h0), 16'(nw_q - base));
        if (ew[4]) chk("addr", a & 16'h7fff, wa_q);
        if (ew[3]) chk("caddr", a & 16'h003f, wa_q);
        if (ew[4] || ew[3]) chk("wdata", 16'(a[7:0] ^ 8'hc3), 16'(wd_q));
    endtask : op
    task automatic tally_and_finish;
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        fork
            begin
                op(5'b01111, 1'b1, 16'hd234, 5, 3'h1, 5'h10);
                op(5'b01111, 1'b1, 16'h0100, 4, 3'h1, 5'h00);
                op(5'b01101, 1'b1, 16'hffc5, 5, 3'h3, 5'h08);
                op(5'b00011, 1'b0, 16'h9234, 5, 3'h2, 5'h00);
                op(5'b01011, 1'b0, 16'h00a7, 5, 3'h2, 5'h00);
                op(5'b00000, 1'b0, 16'h0031, 5, 3'h4, 5'h00);
                op(5'b11111, 1'b1, 16'h0000, 5, 3'h5, 5'h01);
                op(5'b11100, 1'b1, 16'h0000, 5, 3'h6, 5'h02);
                op(5'b10110, 1'b1, 16'h0000, 5, 3'h7, 5'h04);
                prog.drop_reset_pin();
                repeat (10) @(posedge ref_clk);
                chk("mode_no_rst", 16'h0, 16'(mode_state));
            end
            begin
                wait (cyc >= 3000);
                fails++;
                $display("BAD timeout exp %0d got %0d", 3000, cyc);
            end
        join_any
        tally_and_finish();
    end
endmodule : otp_program_mode_decoder_bench
`default_nettype wire
